//--- cmt_pkg.sv
// cmt_pkg: constants, register map and carrier types of the colour matrix transform
// assumes a 32-bit classic wishbone register bus and 8-bit rgb pixels
package cmt_pkg;
	// pixel and coefficient formats; gains are signed q4.12, offsets signed pixel units
	localparam int CMT_PIX_W = 8;
	localparam int CMT_COEF_W = 16;
	localparam int CMT_FRAC = 12;
	localparam int CMT_NCOEF = 12;
	localparam int CMT_NGAIN = 9;
	localparam int CMT_ADR_W = 8;
	// register byte offsets
	localparam logic [7:0] CMT_ADR_PIPE = 8'h00;
	localparam logic [7:0] CMT_ADR_CTRL = 8'h04;
	localparam logic [7:0] CMT_ADR_PRESET = 8'h08;
	localparam logic [7:0] CMT_ADR_CSEL = 8'h0C;
	localparam logic [7:0] CMT_ADR_CVAL = 8'h10;
	localparam logic [7:0] CMT_ADR_SAT = 8'h14;
	localparam logic [7:0] CMT_ADR_WBR = 8'h18;
	localparam logic [7:0] CMT_ADR_WBB = 8'h1C;
	// control register bit positions
	localparam int CMT_CTRL_PICKER = 0;
	localparam int CMT_CTRL_ON = 1;
	localparam int CMT_CTRL_YUV = 2;
	localparam int CMT_CTRL_GAMMA = 3;
	localparam int CMT_CTRL_SAT = 4;
	// reset values and preset shaping
	localparam logic [15:0] CMT_UNITY = 16'h1000;
	localparam logic [15:0] CMT_PRESET_STEP = 16'h0040;
	localparam logic [15:0] CMT_WB_STEP = 16'h0080;
	localparam logic [7:0] CMT_RST_SAT = 8'h80;
	localparam logic [2:0] CMT_RST_PRESET = 3'h0;
	localparam logic [2:0] CMT_PRESET_CUSTOM = 3'h7;
	localparam logic [CMT_PIX_W-1:0] CMT_MID = 8'h80;
	// fixed luma/chroma matrix, rows y, cb, cr, then offsets
	localparam logic [15:0] CMT_YUV_COEF [CMT_NCOEF] = '{
		16'h04C9, 16'h0964, 16'h01D3,
		16'hFD4C, 16'hFAB4, 16'h0800,
		16'h0800, 16'hF94C, 16'hFEB4,
		16'h0000, 16'h0080, 16'h0080};

	typedef enum logic {CMT_PICK_RGB = 1'b0, CMT_PICK_YUV = 1'b1} cmt_pick_t;

	typedef struct packed {
		logic [CMT_PIX_W-1:0] r;
		logic [CMT_PIX_W-1:0] g;
		logic [CMT_PIX_W-1:0] b;
	} cmt_pixel_t;

	typedef struct packed {
		logic pipeOn;
		cmt_pick_t picker;
		logic transformOn;
		logic formatYuv;
		logic gammaOn;
		logic satOn;
		logic [2:0] preset;
		logic [3:0] coefSel;
		logic [7:0] sat;
		logic [15:0] wbRed;
		logic [15:0] wbBlue;
	} cmt_regs_t;
endpackage : cmt_pkg

//--- cmt_top.sv
// cmt_top: per-pixel colour matrix, saturation, gamma and luma/chroma stage
// assumes one clock, wishbone master and pipeline neighbours on that same clock
//
// Operation
// - output channels are gain matrix times rgb plus offsets
// - two transforms, colour correction and luma chroma conversion
// - transform_on bypasses or applies the colour correction
// - illuminant_preset picks a calibrated correction matrix
// - custom preset applies user written coefficients
// - luma chroma conversion follows correction and gamma
// - conversion runs only for yuv pixel format
// - coefficient_value reads the coefficient in use
// - controls reachable only while image_pipe_on set
// - coefficient_picker addresses nine gains, three offsets
// - transform_on read-only while conversion picked
// - calibrated preset choice loads white balance ratios; custom preset keeps them
//
// The Wishbone register port and the address map were decided locally.
`timescale 1ns/10ps
module cmt_top
	import cmt_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [CMT_ADR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// upstream pixels
	input wire logic inValid,
	output logic inReady,
	input cmt_pixel_t inPixel,
	// downstream pixels
	output logic outValid,
	input wire logic outReady,
	output cmt_pixel_t outPixel,
	// ratios handed to the white balance stage
	output logic [15:0] wbRedRatio,
	output logic [15:0] wbBlueRatio
);

	cmt_regs_t regs;
	cmt_regs_t next_regs;
	logic [15:0] userCoef [CMT_NCOEF];
	logic [15:0] next_userCoef [CMT_NCOEF];
	logic [15:0] rgbCoef [CMT_NCOEF];
	logic [31:0] next_dat_o;
	logic next_ack_o;
	logic next_outValid;
	cmt_pixel_t next_outPixel;
	logic access;
	logic wrAccess;
	logic [31:0] wrWord;
	logic [31:0] readWord;
	logic [15:0] readCoef;
	cmt_pixel_t stCorr;
	cmt_pixel_t stSat;
	cmt_pixel_t stGamma;
	cmt_pixel_t stConv;

	// calibrated presets: identity with a red/blue tilt per step
	function automatic logic [15:0] presetCoef(input logic [2:0] p, input int idx);
		logic [15:0] tilt;
		tilt = 16'(16'(p) * CMT_PRESET_STEP);
		if (idx == 0)
			presetCoef = CMT_UNITY + tilt;
		else if (idx == 8)
			presetCoef = CMT_UNITY - tilt;
		else if (idx == 4)
			presetCoef = CMT_UNITY;
		else
			presetCoef = 16'h0000;
	endfunction : presetCoef

	// saturating conversion, never wraps
	function automatic logic [CMT_PIX_W-1:0] clampPix(input logic signed [31:0] v);
		if (v < 0)
			clampPix = '0;
		else if (v > 32'sd255)
			clampPix = '1;
		else
			clampPix = v[CMT_PIX_W-1:0];
	endfunction : clampPix

	function automatic logic signed [31:0] widen(input logic [CMT_PIX_W-1:0] ch);
		widen = signed'({24'h000000, ch});
	endfunction : widen

	// matrix times rgb plus offset triplet, rounded, then clamped
	function automatic cmt_pixel_t applyMatrix(input logic [15:0] c [CMT_NCOEF], input cmt_pixel_t p);
		logic signed [31:0] px [3];
		logic signed [31:0] acc;
		logic [CMT_PIX_W-1:0] ch [3];
		px[0] = widen(p.r);
		px[1] = widen(p.g);
		px[2] = widen(p.b);
		for (int k = 0; k < 3; k++) begin
			acc = 32'(signed'(c[3*k]) * px[0]);
			acc = acc + 32'(signed'(c[3*k+1]) * px[1]);
			acc = acc + 32'(signed'(c[3*k+2]) * px[2]);
			// widen before shifting, or an offset loses its upper bits
			acc = acc + (32'(signed'(c[CMT_NGAIN+k])) <<< CMT_FRAC);
			acc = acc + (32'sd1 <<< (CMT_FRAC - 1));
			ch[k] = clampPix(acc >>> CMT_FRAC);
		end
		applyMatrix = {ch[0], ch[1], ch[2]};
	endfunction : applyMatrix

	// two-segment gamma: steep below a quarter of range, 2/3 slope above
	function automatic logic [CMT_PIX_W-1:0] gammaCh(input logic [CMT_PIX_W-1:0] x);
		logic [15:0] t;
		t = 16'h0000;
		if (x < 8'h40) begin
			gammaCh = 8'({x, 1'b0});
		end else begin
			t = 16'(16'(x - 8'h40) * 16'h00AB);
			gammaCh = 8'h80 + t[15:8];
		end
	endfunction : gammaCh

	// push each channel away from a cheap luma by sat/128
	function automatic cmt_pixel_t saturate(input cmt_pixel_t p, input logic [7:0] s);
		logic signed [31:0] luma;
		logic signed [31:0] px [3];
		logic [CMT_PIX_W-1:0] ch [3];
		px[0] = widen(p.r);
		px[1] = widen(p.g);
		px[2] = widen(p.b);
		luma = (px[0] + 2 * px[1] + px[2]) >>> 2;
		for (int k = 0; k < 3; k++)
			ch[k] = clampPix(luma + (((px[k] - luma) * widen(s)) >>> 7));
		saturate = {ch[0], ch[1], ch[2]};
	endfunction : saturate

	// byte-lane merge of a write into the old word
	function automatic logic [31:0] mergeLanes(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] sel);
		for (int i = 0; i < 4; i++)
			mergeLanes[8*i +: 8] = sel[i] ? nw[8*i +: 8] : old[8*i +: 8];
	endfunction : mergeLanes

	// coefficients of the correction currently in use
	// presets are computed, not stored, so only the custom set costs flops
	always_comb begin
		for (int i = 0; i < CMT_NCOEF; i++)
			rgbCoef[i] = (regs.preset == CMT_PRESET_CUSTOM) ? userCoef[i] : presetCoef(regs.preset, i);
	end

	// coefficient readback for the picked transform
	always_comb begin
		readCoef = 16'h0000;
		if (regs.coefSel < 4'(CMT_NCOEF)) begin
			if (regs.picker == CMT_PICK_YUV)
				readCoef = CMT_YUV_COEF[regs.coefSel];
			else
				readCoef = rgbCoef[regs.coefSel];
		end
	end

	// register read mux; everything but the pipe enable hides while the pipe is off
	always_comb begin
		readWord = 32'h00000000;
		if (adr_i == CMT_ADR_PIPE) begin
			readWord[0] = regs.pipeOn;
		end else if (regs.pipeOn) begin
			case (adr_i)
				CMT_ADR_CTRL: begin
					readWord[CMT_CTRL_PICKER] = regs.picker;
					readWord[CMT_CTRL_ON] = (regs.picker == CMT_PICK_YUV) ? regs.formatYuv : regs.transformOn;
					readWord[CMT_CTRL_YUV] = regs.formatYuv;
					readWord[CMT_CTRL_GAMMA] = regs.gammaOn;
					readWord[CMT_CTRL_SAT] = regs.satOn;
				end
				CMT_ADR_PRESET: readWord[2:0] = regs.preset;
				CMT_ADR_CSEL: readWord[3:0] = regs.coefSel;
				CMT_ADR_CVAL: readWord[15:0] = readCoef;
				CMT_ADR_SAT: readWord[7:0] = regs.sat;
				CMT_ADR_WBR: readWord[15:0] = regs.wbRed;
				CMT_ADR_WBB: readWord[15:0] = regs.wbBlue;
				default: readWord = 32'h00000000;
			endcase
		end
	end

	// ack is registered; a strobe held past ack sees it high and is not taken twice
	assign access = cyc_i && stb_i && !ack_o;
	assign wrAccess = access && we_i;

	// bus answer and register writes
	always_comb begin
		next_regs = regs;
		next_userCoef = userCoef;
		next_ack_o = access;
		next_dat_o = (access && !we_i) ? readWord : dat_o;
		wrWord = 32'h00000000;
		if (wrAccess) begin
			if (adr_i == CMT_ADR_PIPE) begin
				wrWord = mergeLanes({31'h0, regs.pipeOn}, dat_i, sel_i);
				next_regs.pipeOn = wrWord[0];
			end else if (regs.pipeOn) begin
				case (adr_i)
					CMT_ADR_CTRL: begin
						wrWord = mergeLanes(readWord, dat_i, sel_i);
						next_regs.picker = cmt_pick_t'(wrWord[CMT_CTRL_PICKER]);
						if (regs.picker == CMT_PICK_RGB)
							next_regs.transformOn = wrWord[CMT_CTRL_ON];
						next_regs.formatYuv = wrWord[CMT_CTRL_YUV];
						next_regs.gammaOn = wrWord[CMT_CTRL_GAMMA];
						next_regs.satOn = wrWord[CMT_CTRL_SAT];
					end
					CMT_ADR_PRESET: begin
						wrWord = mergeLanes(readWord, dat_i, sel_i);
						next_regs.preset = wrWord[2:0];
						if (wrWord[2:0] != CMT_PRESET_CUSTOM) begin
							next_regs.wbRed = CMT_UNITY + 16'(16'(wrWord[2:0]) * CMT_WB_STEP);
							next_regs.wbBlue = CMT_UNITY - 16'(16'(wrWord[2:0]) * CMT_WB_STEP);
						end
					end
					CMT_ADR_CSEL: begin
						wrWord = mergeLanes(readWord, dat_i, sel_i);
						next_regs.coefSel = wrWord[3:0];
					end
					CMT_ADR_CVAL: begin
						wrWord = mergeLanes(readWord, dat_i, sel_i);
						// only user coefficients are writable; presets and the fixed matrix stay
						if (regs.picker == CMT_PICK_RGB && regs.preset == CMT_PRESET_CUSTOM
								&& regs.coefSel < 4'(CMT_NCOEF))
							next_userCoef[regs.coefSel] = wrWord[15:0];
					end
					CMT_ADR_SAT: begin
						wrWord = mergeLanes(readWord, dat_i, sel_i);
						next_regs.sat = wrWord[7:0];
					end
					CMT_ADR_WBR: begin
						wrWord = mergeLanes(readWord, dat_i, sel_i);
						next_regs.wbRed = wrWord[15:0];
					end
					CMT_ADR_WBB: begin
						wrWord = mergeLanes(readWord, dat_i, sel_i);
						next_regs.wbBlue = wrWord[15:0];
					end
					default: wrWord = 32'h00000000;
				endcase
			end
		end
	end

	// pixel path: correction, saturation, gamma, then luma/chroma last
	// settings are read at take time; a write between pixels applies to the next one
	always_comb begin
		stCorr = (regs.pipeOn && regs.transformOn) ? applyMatrix(rgbCoef, inPixel) : inPixel;
		stSat = (regs.pipeOn && regs.satOn) ? saturate(stCorr, regs.sat) : stCorr;
		stGamma = stSat;
		if (regs.pipeOn && regs.gammaOn) begin
			stGamma.r = gammaCh(stSat.r);
			stGamma.g = gammaCh(stSat.g);
			stGamma.b = gammaCh(stSat.b);
		end
		stConv = (regs.pipeOn && regs.formatYuv) ? applyMatrix(CMT_YUV_COEF, stGamma) : stGamma;
	end

	// one output register; a stalled sink holds the pixel and stalls the source
	assign inReady = !outValid || outReady;

	always_comb begin
		next_outValid = inReady ? inValid : outValid;
		next_outPixel = (inReady && inValid) ? stConv : outPixel;
	end

	assign wbRedRatio = regs.wbRed;
	assign wbBlueRatio = regs.wbBlue;

	// synchronous reset; user coefficients restart as identity
	always_ff @(posedge clk) begin
		if (rst) begin
			regs <= '{pipeOn: 1'b0, picker: CMT_PICK_RGB, transformOn: 1'b0, formatYuv: 1'b0,
				gammaOn: 1'b0, satOn: 1'b0, preset: CMT_RST_PRESET, coefSel: 4'h0,
				sat: CMT_RST_SAT, wbRed: CMT_UNITY, wbBlue: CMT_UNITY};
			for (int i = 0; i < CMT_NCOEF; i++)
				userCoef[i] <= presetCoef(CMT_RST_PRESET, i);
			dat_o <= 32'h00000000;
			ack_o <= 1'b0;
			outValid <= 1'b0;
			outPixel <= '0;
		end else begin
			regs <= next_regs;
			userCoef <= next_userCoef;
			dat_o <= next_dat_o;
			ack_o <= next_ack_o;
			outValid <= next_outValid;
			outPixel <= next_outPixel;
		end
	end

endmodule : cmt_top

//--- cmt_properties.sv
// cmt_properties: port-level checks of the colour matrix transform
// assumes one clock domain; bound onto every cmt_top instance
`timescale 1ns/10ps
module cmt_checker
	import cmt_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register bus
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [CMT_ADR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// pixel stream
	input wire logic inValid,
	input wire logic inReady,
	input cmt_pixel_t inPixel,
	input wire logic outValid,
	input wire logic outReady,
	input cmt_pixel_t outPixel,
	// white balance ratios
	input wire logic [15:0] wbRedRatio,
	input wire logic [15:0] wbBlueRatio
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// mirror of the pipe enable, followed from taken writes only
	logic pipeOn, next_pipeOn;
	wire logic take = cyc_i && stb_i && !ack_o;
	always_comb next_pipeOn = (take && we_i && adr_i == CMT_ADR_PIPE && sel_i[0]) ? dat_i[0] : pipeOn;
	always_ff @(posedge clk) pipeOn <= rst ? 1'b0 : next_pipeOn;

	property p_ackTake; take |=> ack_o; endproperty
	a_ackTake: assert property (p_ackTake) else $error("no ack after request");
	property p_hold; outValid && !outReady |=> outValid && $stable(outPixel); endproperty
	a_hold: assert property (p_hold) else $error("output pixel dropped under stall");
	property p_backPress; outValid && !outReady |-> !inReady; endproperty
	a_backPress: assert property (p_backPress) else $error("input ready under stall");
	property p_take; inValid && inReady |=> outValid; endproperty
	a_take: assert property (p_take) else $error("taken pixel not presented");
	property p_drop; outValid && outReady && !(inValid && inReady) |=> !outValid; endproperty
	a_drop: assert property (p_drop) else $error("output valid stuck");
	property p_bypass; inValid && inReady && !pipeOn |=> outPixel == $past(inPixel); endproperty
	a_bypass: assert property (p_bypass) else $error("pixel altered with pipe off");
	property p_offRead; take && !we_i && !pipeOn && adr_i != CMT_ADR_PIPE |=> dat_o == 32'h0; endproperty
	a_offRead: assert property (p_offRead) else $error("control readable with pipe off");
	property p_ratio; $changed({wbRedRatio, wbBlueRatio}) |-> $past(take && we_i); endproperty
	a_ratio: assert property (p_ratio) else $error("ratio moved without a write");
	c_stall: cover property (outValid && !outReady);
	c_offRead: cover property (ack_o && !pipeOn);
	c_onPixel: cover property (inValid && inReady && pipeOn);
endmodule : cmt_checker

bind cmt_top cmt_checker cmt_chk (.clk(clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .inValid(inValid), .inReady(inReady),
	.inPixel(inPixel), .outValid(outValid), .outReady(outReady), .outPixel(outPixel), .wbRedRatio(wbRedRatio),
	.wbBlueRatio(wbBlueRatio));

//--- cmt_pipe_model.sv
// cmt_pipe_model: upstream source and downstream sink around the block
// assumes the block's clock; sink stalls every other cycle while slow is high
`timescale 1ns/10ps
module cmt_pipe_model
	import cmt_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// source side
	output logic inValid,
	input wire logic inReady,
	output cmt_pixel_t inPixel,
	// sink side
	input wire logic outValid,
	output logic outReady,
	input cmt_pixel_t outPixel,
	// stall pattern
	input wire logic slow
);
	cmt_pixel_t got[$];
	logic phase = 1'b0;
	initial begin
		inValid = 1'b0;
		inPixel = '0;
	end
	always @(posedge clk) begin
		phase <= rst ? 1'b0 : ~phase;
		outReady <= !slow || phase;
		if (outValid && outReady) got.push_back(outPixel);
	end
	// released data shows the inverse so a stale pixel never looks valid
	task automatic send(input cmt_pixel_t p, input logic last);
		inValid <= 1'b1;
		inPixel <= p;
		@(posedge clk);
		while (!inReady) @(posedge clk);
		if (last) begin
			inValid <= 1'b0;
			inPixel <= ~p;
		end
	endtask : send
endmodule : cmt_pipe_model

//--- tb.sv
// tb: register and pixel sequences against the colour matrix transform
// assumes cmt_checker is bound in and cmt_pipe_model stands at the pixel ports
`timescale 1ns/10ps
module tb
	import cmt_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic slow = 1'b0;
	logic [7:0] adr = '0;
	logic [31:0] dat = '0;
	logic [31:0] q, rdat;
	logic ack, inValid, inReady, outValid, outReady;
	logic [15:0] wbR, wbB;
	cmt_pixel_t inPixel, outPixel;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;
	cmt_top uut (.clk(clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF),
		.dat_i(dat), .dat_o(rdat), .ack_o(ack), .inValid(inValid), .inReady(inReady), .inPixel(inPixel),
		.outValid(outValid), .outReady(outReady), .outPixel(outPixel), .wbRedRatio(wbR), .wbBlueRatio(wbB));
	cmt_pipe_model pm (.clk(clk), .rst(rst), .inValid(inValid), .inReady(inReady), .inPixel(inPixel),
		.outValid(outValid), .outReady(outReady), .outPixel(outPixel), .slow(slow));
	initial forever #20 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			failures++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("failures=%0d comparisons=%0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// ack is the only completion; the global cycle ceiling ends a hang
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		wb(1'b0, a, 32'h0);
		chk(q, {16'h0000, e});
	endtask : rd
	task automatic px(input cmt_pixel_t a, input cmt_pixel_t ea, input cmt_pixel_t b, input cmt_pixel_t eb);
		pm.send(a, 1'b0);
		pm.send(b, 1'b1);
		repeat (20) if (pm.got.size() < 2) @(posedge clk);
		chk({8'h00, pm.got.pop_front()}, {8'h00, ea});
		chk({8'h00, pm.got.pop_front()}, {8'h00, eb});
	endtask : px
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		chk({16'h0, wbR}, 32'h1000);
		wb(1'b1, CMT_ADR_CTRL, 32'h2);
		px(24'h102030, 24'h102030, 24'h405060, 24'h405060);
		rd(CMT_ADR_SAT, 16'h0);
		wb(1'b1, CMT_ADR_PIPE, 32'h1);
		rd(CMT_ADR_PIPE, 16'h1);
		rd(CMT_ADR_SAT, 16'h0080);
		rd(CMT_ADR_CTRL, 16'h0);
		rd(8'h20, 16'h0);
		wb(1'b1, CMT_ADR_CTRL, 32'h2);
		rd(CMT_ADR_CTRL, 16'h2);
		wb(1'b1, CMT_ADR_PRESET, 32'h3);
		chk({wbR, wbB}, 32'h11800E80);
		wb(1'b1, CMT_ADR_CSEL, 32'h0);
		rd(CMT_ADR_CVAL, 16'h10C0);
		wb(1'b1, CMT_ADR_CSEL, 32'h8);
		rd(CMT_ADR_CVAL, 16'h0F40);
		slow <= 1'b1;
		px(24'hFF1080, 24'hFF107A, 24'h808080, 24'h86807A);
		slow <= 1'b0;
		wb(1'b1, CMT_ADR_CTRL, 32'h0);
		px(24'hFF1080, 24'hFF1080, 24'h405060, 24'h405060);
		wb(1'b1, CMT_ADR_PRESET, 32'h7);
		wb(1'b1, CMT_ADR_CSEL, 32'h9);
		wb(1'b1, CMT_ADR_CVAL, 32'hFFF0);
		rd(CMT_ADR_CVAL, 16'hFFF0);
		chk({wbR, wbB}, 32'h11800E80);
		wb(1'b1, CMT_ADR_CTRL, 32'h2);
		px(24'h082030, 24'h002030, 24'h902030, 24'h802030);
		// enable set under rgb while the picker moves to yuv in the same word
		wb(1'b1, CMT_ADR_CTRL, 32'h3);
		rd(CMT_ADR_CTRL, 16'h1);
		wb(1'b1, CMT_ADR_CSEL, 32'h0);
		rd(CMT_ADR_CVAL, 16'h04C9);
		wb(1'b1, CMT_ADR_CSEL, 32'hA);
		rd(CMT_ADR_CVAL, 16'h0080);
		// the old picker decides: these writes of 0 must not clear the enable
		wb(1'b1, CMT_ADR_CTRL, 32'h1);
		wb(1'b1, CMT_ADR_CTRL, 32'h0);
		rd(CMT_ADR_CTRL, 16'h2);
		wb(1'b1, CMT_ADR_CTRL, 32'h4);
		px(24'hFF0000, 24'h4C55FF, 24'h808080, 24'h808080);
		wb(1'b1, CMT_ADR_CTRL, 32'h8);
		px(24'h202020, 24'h404040, 24'h808080, 24'hAAAAAA);
		wb(1'b1, CMT_ADR_CTRL, 32'hC);
		px(24'h202020, 24'h408080, 24'h808080, 24'hAA8080);
		wb(1'b1, CMT_ADR_SAT, 32'h0);
		wb(1'b1, CMT_ADR_CTRL, 32'h10);
		px(24'hC04040, 24'h606060, 24'h808080, 24'h808080);
		wb(1'b1, CMT_ADR_SAT, 32'hFF);
		px(24'hC04040, 24'hFF2020, 24'h808080, 24'h808080);
		finish_test();
	end
endmodule : tb
